// [design/i2csr_defs.svh]
`ifndef I2CSR_DEFS_SVH
`define I2CSR_DEFS_SVH
`define I2CSR_BYTE_BITS 8
`define I2CSR_ADDR_BITS 7
`define I2CSR_RW_BIT 0
`define I2CSR_ACK_CLK 4'h9
`define I2CSR_LAST_BIT_CLK 4'h8
`endif

// [design/i2csr_pkg.sv]
package i2csr_pkg;
  typedef enum logic [3:0] {
    I2CSR_IDLE = 4'b0001,
    I2CSR_SHIFT = 4'b0010,
    I2CSR_ACK = 4'b0100,
    I2CSR_SKIP = 4'b1000
  } i2csr_state_e;
endpackage : i2csr_pkg

// [design/i2csr_line_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface i2csr_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
  modport dst (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface : i2csr_line_if
`default_nettype wire

// [design/i2csr_line_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for scl and sda, then edge and start/stop detection
module i2csr_line_sync (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  i2csr_line_if.src line
);
  logic [1:0] meta_reg;
  logic [1:0] meta_next;
  logic [1:0] sync_reg;
  logic [1:0] sync_next;
  logic [1:0] prev_reg;
  logic [1:0] prev_next;

  always_comb begin
    meta_next = {scl_i, sda_i};
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
      prev_reg <= 2'h3;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign line.scl = sync_reg[1];
  assign line.sda = sync_reg[0];
  assign line.scl_rise = sync_reg[1] & ~prev_reg[1];
  assign line.scl_fall = ~sync_reg[1] & prev_reg[1];
  // sda moving while scl stays high marks start or stop
  assign line.start_det = sync_reg[1] & prev_reg[1] & prev_reg[0] & ~sync_reg[0];
  assign line.stop_det = sync_reg[1] & prev_reg[1] & ~prev_reg[0] & sync_reg[0];
endmodule : i2csr_line_sync
`default_nettype wire

// [design/i2csr_rx.sv]
// Summary of operation
// - address match with write bit zero clears the read/write status bit.
// - a matching address byte is placed into the receive buffer.
// - overflow at address byte end means no acknowledge, sda left released.
// - overflow means buffer-full set or receive-overflow set.
// - interrupt flag is set once per byte addressed to us, acknowledged or not; a foreign address byte sets no flag.
// - bits sampled on scl rise; address compared at eighth scl fall.
// - clean match loads buffer, sets full, acknowledges, flags at eighth fall.
// - overflow only: load without acknowledge; buffer full: no load, no acknowledge.
// - buffer read clears full; overflow cleared only by software write.
`timescale 1ns/1ps
`default_nettype none
`include "i2csr_defs.svh"
module i2csr_rx (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic enable_i,
  input wire logic [`I2CSR_ADDR_BITS-1:0] slave_address_reg_i,
  input wire logic buffer_read_i,
  input wire logic overflow_clear_i,
  input wire logic irq_flag_clear_i,
  output logic [`I2CSR_BYTE_BITS-1:0] rx_tx_buffer_o,
  output logic buffer_full_flag_o,
  output logic receive_overflow_flag_o,
  output logic port_interrupt_flag_o,
  output logic read_write_flag_o,
  output logic data_not_address_o
);
  i2csr_line_if line ();
  i2csr_line_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .line(line)
  );

  i2csr_pkg::i2csr_state_e state_reg;
  i2csr_pkg::i2csr_state_e state_next;
  logic [3:0] bitcnt_reg;
  logic [3:0] bitcnt_next;
  logic [`I2CSR_BYTE_BITS-1:0] serial_shift_reg;
  logic [`I2CSR_BYTE_BITS-1:0] serial_shift_next;
  logic addr_phase_reg;
  logic addr_phase_next;
  logic ack_reg;
  logic ack_next;
  logic [`I2CSR_BYTE_BITS-1:0] buf_reg;
  logic [`I2CSR_BYTE_BITS-1:0] buf_next;
  logic bf_reg;
  logic bf_next;
  logic ov_reg;
  logic ov_next;
  logic irq_reg;
  logic irq_next;
  logic rw_reg;
  logic rw_next;
  logic da_reg;
  logic da_next;
  logic overflow;
  logic addr_match;
  logic byte_done;

  assign overflow = bf_reg | ov_reg;
  assign addr_match = serial_shift_reg[`I2CSR_BYTE_BITS-1:1] == slave_address_reg_i;
  // byte end is the eighth scl fall
  assign byte_done = (state_reg == i2csr_pkg::I2CSR_SHIFT) && line.scl_fall &&
                     (bitcnt_reg == `I2CSR_LAST_BIT_CLK);

  always_comb begin
    state_next = state_reg;
    bitcnt_next = bitcnt_reg;
    serial_shift_next = serial_shift_reg;
    addr_phase_next = addr_phase_reg;
    ack_next = ack_reg;
    buf_next = buf_reg;
    bf_next = bf_reg;
    ov_next = ov_reg;
    irq_next = irq_reg;
    rw_next = rw_reg;
    da_next = da_reg;
    // software clears first so a same-cycle hardware set wins
    if (buffer_read_i) begin
      bf_next = 1'b0;
    end
    if (overflow_clear_i) begin
      ov_next = 1'b0;
    end
    if (irq_flag_clear_i) begin
      irq_next = 1'b0;
    end
    case (state_reg)
      i2csr_pkg::I2CSR_IDLE: begin
        ack_next = 1'b0;
      end
      i2csr_pkg::I2CSR_SHIFT: begin
        if (line.scl_rise) begin
          serial_shift_next = {serial_shift_reg[`I2CSR_BYTE_BITS-2:0], line.sda};
          bitcnt_next = bitcnt_reg + 4'h1;
        end
        if (byte_done) begin
          // another slave's address is not a byte for us: no flag, no ack
          if (addr_phase_reg && !addr_match) begin
            state_next = i2csr_pkg::I2CSR_SKIP;
          end else begin
            irq_next = 1'b1;
            state_next = i2csr_pkg::I2CSR_ACK;
            ack_next = !overflow;
            if (!bf_reg) begin
              buf_next = serial_shift_reg;
              bf_next = 1'b1;
            end else begin
              ov_next = 1'b1;
            end
            if (addr_phase_reg) begin
              da_next = 1'b0;
              rw_next = serial_shift_reg[`I2CSR_RW_BIT];
            end else begin
              da_next = 1'b1;
            end
          end
        end
      end
      i2csr_pkg::I2CSR_ACK: begin
        // ack held through the ninth clock, released at its falling edge
        if (line.scl_fall) begin
          ack_next = 1'b0;
          addr_phase_next = 1'b0;
          bitcnt_next = 4'h0;
          // read transfers are not served by this receive path
          state_next = rw_reg ? i2csr_pkg::I2CSR_SKIP : i2csr_pkg::I2CSR_SHIFT;
        end
      end
      i2csr_pkg::I2CSR_SKIP: begin
        ack_next = 1'b0;
      end
      default: begin
        state_next = i2csr_pkg::I2CSR_IDLE;
      end
    endcase
    if (line.start_det) begin
      state_next = i2csr_pkg::I2CSR_SHIFT;
      bitcnt_next = 4'h0;
      addr_phase_next = 1'b1;
      ack_next = 1'b0;
    end else if (line.stop_det) begin
      state_next = i2csr_pkg::I2CSR_IDLE;
      ack_next = 1'b0;
    end
    if (!enable_i) begin
      state_next = i2csr_pkg::I2CSR_IDLE;
      ack_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= i2csr_pkg::I2CSR_IDLE;
      bitcnt_reg <= 4'h0;
      serial_shift_reg <= 8'h00;
      addr_phase_reg <= 1'b0;
      ack_reg <= 1'b0;
      buf_reg <= 8'h00;
      bf_reg <= 1'b0;
      ov_reg <= 1'b0;
      irq_reg <= 1'b0;
      rw_reg <= 1'b0;
      da_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_next;
      serial_shift_reg <= serial_shift_next;
      addr_phase_reg <= addr_phase_next;
      ack_reg <= ack_next;
      buf_reg <= buf_next;
      bf_reg <= bf_next;
      ov_reg <= ov_next;
      irq_reg <= irq_next;
      rw_reg <= rw_next;
      da_reg <= da_next;
    end
  end

  // open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_o = ack_reg;
  assign rx_tx_buffer_o = buf_reg;
  assign buffer_full_flag_o = bf_reg;
  assign receive_overflow_flag_o = ov_reg;
  assign port_interrupt_flag_o = irq_reg;
  assign read_write_flag_o = rw_reg;
  assign data_not_address_o = da_reg;

  ovf_noack_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    byte_done && overflow |=> !sda_oe_o)
    else $error("acknowledge driven despite overflow");
  clean_ack_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    byte_done && !overflow && (!addr_phase_reg || addr_match) && enable_i && !line.start_det
    && !line.stop_det |=> sda_oe_o && buffer_full_flag_o && port_interrupt_flag_o)
    else $error("clean byte not acknowledged and flagged");
  irq_every_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    byte_done && (!addr_phase_reg || addr_match) |=> port_interrupt_flag_o)
    else $error("interrupt flag missing after byte");
  miss_noirq_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    byte_done && addr_phase_reg && !addr_match && !port_interrupt_flag_o
    |=> !port_interrupt_flag_o)
    else $error("interrupt flag set for a foreign address");
  irq_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    port_interrupt_flag_o && !irq_flag_clear_i |=> port_interrupt_flag_o)
    else $error("interrupt flag cleared by hardware");
  bf_noload_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    byte_done && bf_reg |=> $stable(rx_tx_buffer_o))
    else $error("buffer loaded while full");
  addr_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    byte_done && addr_phase_reg && addr_match && !bf_reg |=>
    rx_tx_buffer_o == $past(serial_shift_reg))
    else $error("address byte not loaded");
  rw_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    byte_done && addr_phase_reg && addr_match && !serial_shift_reg[0] |=> !read_write_flag_o)
    else $error("read/write bit not cleared");
  ov_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    receive_overflow_flag_o && !overflow_clear_i |=> receive_overflow_flag_o)
    else $error("overflow cleared without software");
  bf_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    buffer_read_i && !byte_done |=> !buffer_full_flag_o)
    else $error("buffer read did not clear full");

  clean_byte_c: cover property (@(posedge sys_clk_i) byte_done && !overflow);
  ovf_byte_c: cover property (@(posedge sys_clk_i) byte_done && ov_reg && !bf_reg);
  full_byte_c: cover property (@(posedge sys_clk_i) byte_done && bf_reg);
endmodule : i2csr_rx
`default_nettype wire

// [tb/i2csr_bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
// bus master model: scl stands high between frames, sda is open drain (1 = released)
module i2csr_bus_master (
  input wire logic sys_clk_i,
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_rel_o
);
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
  end
  // a quarter of the 160 ns bus period, counted on falling edges of the core clock
  task automatic quarter();
    repeat (2) @(negedge sys_clk_i);
  endtask : quarter
  // also serves as repeated start when scl is low
  task automatic start_cond();
    sda_rel_o = 1'b1;
    quarter();
    scl_o = 1'b1;
    quarter();
    sda_rel_o = 1'b0;
    quarter();
    scl_o = 1'b0;
    quarter();
  endtask : start_cond
  task automatic send_byte(input logic [7:0] b, output logic ack_low);
    for (int i = 7; i >= 0; i--) begin
      sda_rel_o = b[i];
      quarter();
      scl_o = 1'b1;
      quarter();
      quarter();
      scl_o = 1'b0;
      quarter();
    end
    sda_rel_o = 1'b1;
    quarter();
    scl_o = 1'b1;
    quarter();
    ack_low = !sda_line_i;
    quarter();
    scl_o = 1'b0;
    quarter();
  endtask : send_byte
  task automatic stop_cond();
    sda_rel_o = 1'b0;
    quarter();
    quarter();
    scl_o = 1'b1;
    quarter();
    sda_rel_o = 1'b1;
    quarter();
  endtask : stop_cond
endmodule : i2csr_bus_master
`default_nettype wire

// [tb/i2c_slave_receive_path_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h expected %h", $time, got, exp); end end
module i2c_slave_receive_path_tb;
  logic sys_clk, rst_n, scl, sda_rel, sda_line, sda_o, sda_oe, ack;
  logic buf_rd, ov_clr, irq_clr, bf, ov, irq, rw, da;
  logic [7:0] rx_byte;
  int mismatches, total_checks, cycles;
  // pull-up on the data wire; the slave can only pull it low
  assign sda_line = sda_rel & (sda_oe ? sda_o : 1'b1);
  i2csr_bus_master u_master (.sys_clk_i(sys_clk), .sda_line_i(sda_line), .scl_o(scl),
    .sda_rel_o(sda_rel));
  i2csr_rx u_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .enable_i(1'b1), .slave_address_reg_i(7'h5A),
    .buffer_read_i(buf_rd), .overflow_clear_i(ov_clr), .irq_flag_clear_i(irq_clr),
    .rx_tx_buffer_o(rx_byte), .buffer_full_flag_o(bf), .receive_overflow_flag_o(ov),
    .port_interrupt_flag_o(irq), .read_write_flag_o(rw), .data_not_address_o(da));
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // software pulses {buffer read, overflow clear, irq clear}
  task automatic sw(input logic [2:0] m);
    @(negedge sys_clk);
    {buf_rd, ov_clr, irq_clr} = m;
    @(negedge sys_clk);
    {buf_rd, ov_clr, irq_clr} = 3'h0;
    @(negedge sys_clk);
  endtask : sw
  // flags are {full, overflow, irq, read/write, data}
  task automatic xfer(input logic [7:0] b, input logic e_ack, input logic [7:0] e_buf,
    input logic [4:0] e_fl);
    u_master.send_byte(b, ack);
    `CHK(ack, e_ack)
    `CHK(rx_byte, e_buf)
    `CHK({bf, ov, irq, rw, da}, e_fl)
  endtask : xfer
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    {rst_n, buf_rd, ov_clr, irq_clr} = 4'h0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK({rx_byte, bf, ov, irq, rw, da}, 13'h0000)
    u_master.start_cond();
    xfer(8'hB5, 1'b1, 8'hB5, 5'b10110);
    u_master.stop_cond();
    sw(3'b101);
    `CHK({bf, irq, rw}, 3'b001)
    u_master.start_cond();
    xfer(8'hB4, 1'b1, 8'hB4, 5'b10100);
    sw(3'b101);
    xfer(8'h3C, 1'b1, 8'h3C, 5'b10101);
    sw(3'b001);
    xfer(8'hA5, 1'b0, 8'h3C, 5'b11101);
    repeat (100) @(negedge sys_clk);
    `CHK(irq, 1'b1)
    sw(3'b101);
    `CHK({bf, ov, irq}, 3'b010)
    xfer(8'h69, 1'b0, 8'h69, 5'b11101);
    sw(3'b101);
    u_master.start_cond();
    xfer(8'hB4, 1'b0, 8'hB4, 5'b11100);
    sw(3'b011);
    u_master.start_cond();
    xfer(8'hB4, 1'b0, 8'hB4, 5'b11100);
    u_master.stop_cond();
    sw(3'b111);
    `CHK({bf, ov, irq}, 3'b000)
    u_master.start_cond();
    xfer(8'h10, 1'b0, 8'hB4, 5'b00000);
    u_master.stop_cond();
    repeat (20) @(negedge sys_clk);
    close_out();
  end
endmodule : i2c_slave_receive_path_tb
`default_nettype wire
